// ==== hw/gfx_mi_defines.vh ====
`ifndef GFX_MI_DEFINES_VH
`define GFX_MI_DEFINES_VH

// Alias window within graphics MMIO offsets
`define ALIAS_LO 24'h140000
`define ALIAS_HI 24'h17ffff
`define OFS_W 24

// Access size codes
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_DWORD 2'h2
`define SZ_QWORD 2'h3

// Initiator codes
`define SRC_CPU 4'h0
`define SRC_PEG 4'h1
`define SRC_PEER 4'h2
`define SRC_LINK 4'h3
`define SRC_SNOOP 4'h4
`define SRC_CMD 4'h5
`define SRC_VTX 4'h6
`define SRC_ISC 4'h7
`define SRC_RCC 4'h8
`define SRC_SMP 4'h9
`define SRC_DISP 4'ha

// Graphics memory client request fields
`define GA_W 32
`define PA_W 40
`define PAGE_LSB 12
`define FENCE_N 4
`define TLB_N 4

`endif

// ==== hw/gfx_tiler.v ====
`include "gfx_mi_defines.vh"

// Tiled address swizzle: 4KB tiles, X (512x8) or Y (128x32) walk
module gfx_tiler (
    input wire [31:0] zaddr,
    input wire tiled,
    input wire walk_y,
    input wire [3:0] pitch_tiles_log2,
    output reg [31:0] laddr
);
    reg [31:0] x;
    reg [31:0] y;
    reg [31:0] tx;
    reg [31:0] ty;
    reg [31:0] tile;
    reg [11:0] inner;
    reg [31:0] row_bytes_log2;
    always @* begin
        x = 32'h0;
        y = 32'h0;
        tx = 32'h0;
        ty = 32'h0;
        tile = 32'h0;
        inner = 12'h0;
        row_bytes_log2 = {28'h0, pitch_tiles_log2} + (walk_y ? 32'h7 : 32'h9);
        laddr = zaddr;
        if (tiled) begin
            x = zaddr & ((32'h1 << row_bytes_log2) - 32'h1);
            y = zaddr >> row_bytes_log2;
            if (walk_y) begin
                tx = x >> 7;
                ty = y >> 5;
                inner = {x[6:4], y[4:0], x[3:0]};
            end else begin
                tx = x >> 9;
                ty = y >> 3;
                inner = {y[2:0], x[8:0]};
            end
            tile = (ty << pitch_tiles_log2) + tx;
            laddr = {tile[19:0], inner};
        end
    end
endmodule

// ==== hw/gfx_tlb.v ====
`include "gfx_mi_defines.vh"

// Small fully associative translation cache, one fill port
module gfx_tlb (
    input wire clk,
    input wire nrst,
    input wire flush,
    input wire [19:0] lookup_page,
    output reg hit,
    output reg [27:0] hit_frame,
    input wire fill,
    input wire [19:0] fill_page,
    input wire [27:0] fill_frame
);
    reg [19:0] tag [0:3];
    reg [27:0] frame [0:3];
    reg [3:0] valid;
    reg [1:0] victim;
    integer i;
    always @* begin
        hit = 1'b0;
        hit_frame = 28'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (valid[i] && tag[i] == lookup_page) begin
                hit = 1'b1;
                hit_frame = frame[i];
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ent
            always @(posedge clk) begin
                if (!nrst || flush) begin
                    valid[g] <= 1'b0;
                    tag[g] <= 20'h0;
                    frame[g] <= 28'h0;
                end else if (fill && victim == g) begin
                    valid[g] <= 1'b1;
                    tag[g] <= fill_page;
                    frame[g] <= fill_frame;
                end
            end
        end
    endgenerate
    always @(posedge clk) begin
        if (!nrst || flush)
            victim <= 2'h0;
        else if (fill)
            victim <= victim + 2'h1;
    end
endmodule

// ==== hw/gfx_mi_front.v ====
// Overview of operation
// - Alias window offsets map onto controller registers
// - Only aligned word, dword, qword sizes
// - Attributes forwarded unchanged from controller space
// - Alias reached only by host CPU
// - Command streamer load into alias discarded
// - Command streamer store from alias reads zero
// - Window reachable from function 0 and 1
// - Alias off when memory space or power off
// - External addresses rebased to zero first
// - Tile when fenced or surface says tiled
// - Translate via table and TLB, then access
// - CPU aperture accesses never snoop after translation
// - Host CPU may read and write
// - Expansion port client may only write
// - Peer devices write only, mapped range
// - Register accesses over peer link refused
// - Listed internal clients are read only
// - Render cache rw, snooped client rw snooped
`include "gfx_mi_defines.vh"

module gfx_mi_front (
    // Clock and reset
    input wire CLK,
    input wire NRST,
    // MMIO request from the host side
    input wire MMIO_REQ,
    input wire MMIO_WR,
    input wire MMIO_FUNC,
    input wire [3:0] MMIO_SRC,
    input wire [23:0] MMIO_OFS,
    input wire [1:0] MMIO_SIZE,
    input wire [63:0] MMIO_WDATA,
    input wire [7:0] MMIO_BE,
    // Function enables and power
    input wire FUNC0_MEM_EN,
    input wire FUNC1_MEM_EN,
    input wire ALIAS_POWER_OK,
    // MMIO response
    output reg MMIO_ACK,
    output reg [63:0] MMIO_RDATA,
    output reg MMIO_HIT,
    // Controller register space port
    output reg MC_REQ,
    output reg MC_WR,
    output reg [23:0] MC_OFS,
    output reg [1:0] MC_SIZE,
    output reg [63:0] MC_WDATA,
    output reg [7:0] MC_BE,
    output reg MC_TRUSTED,
    input wire TRUSTED_LAUNCH_MODE,
    input wire MC_ACK,
    input wire [63:0] MC_RDATA,
    // Graphics memory client request
    input wire GM_REQ,
    input wire GM_WR,
    input wire [3:0] GM_SRC,
    input wire [31:0] GM_ADDR,
    input wire GM_EXTERNAL,
    input wire GM_SURF_TILED,
    input wire GM_SURF_WALK_Y,
    input wire [3:0] GM_SURF_PITCH_LOG2,
    input wire [31:0] GM_RANGE_BASE,
    // Fence table, four regions
    input wire [127:0] FENCE_LO,
    input wire [127:0] FENCE_HI,
    input wire [3:0] FENCE_VALID,
    input wire [3:0] FENCE_WALK_Y,
    input wire [15:0] FENCE_PITCH_LOG2,
    // Translation table fetch
    output reg TT_REQ,
    output reg [19:0] TT_PAGE,
    input wire TT_ACK,
    input wire [27:0] TT_FRAME,
    input wire TT_VALID,
    input wire TLB_FLUSH,
    // Physical memory access
    output reg PM_REQ,
    output reg PM_WR,
    output reg [39:0] PM_ADDR,
    output reg PM_SNOOP,
    input wire PM_ACK,
    // Client status
    output reg GM_ACK,
    output reg GM_ERR
);
    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    function in_alias;
        input [23:0] ofs;
        begin
            in_alias = (ofs >= `ALIAS_LO) && (ofs <= `ALIAS_HI);
        end
    endfunction

    function size_ok;
        input [1:0] sz;
        input [23:0] ofs;
        begin
            case (sz)
                `SZ_WORD: size_ok = (ofs[0] == 1'b0);
                `SZ_DWORD: size_ok = (ofs[1:0] == 2'h0);
                `SZ_QWORD: size_ok = (ofs[2:0] == 3'h0);
                default: size_ok = 1'b0;
            endcase
        end
    endfunction

    function client_ok;
        input [3:0] src;
        input wr;
        begin
            case (src)
                `SRC_CPU: client_ok = 1'b1;
                `SRC_PEG: client_ok = wr;
                `SRC_PEER: client_ok = wr;
                `SRC_CMD, `SRC_VTX, `SRC_ISC, `SRC_SMP, `SRC_DISP:
                    client_ok = !wr;
                `SRC_RCC, `SRC_SNOOP: client_ok = 1'b1;
                default: client_ok = 1'b0;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // Input synchronisers for asynchronous enables
    // ---------------------------------------------------------------
    reg [2:0] en_meta;
    reg [2:0] en_sync;
    always @(posedge CLK) begin
        if (!NRST) begin
            en_meta <= 3'h0;
            en_sync <= 3'h0;
        end else begin
            en_meta <= {ALIAS_POWER_OK, FUNC1_MEM_EN, FUNC0_MEM_EN};
            en_sync <= en_meta;
        end
    end

    // ---------------------------------------------------------------
    // MMIO alias path
    // ---------------------------------------------------------------
    localparam M_IDLE = 2'h0;
    localparam M_WAIT = 2'h1;
    reg [1:0] mstate;
    wire func_en = MMIO_FUNC ? en_sync[1] : en_sync[0];
    wire alias_on = func_en && en_sync[2];
    wire alias_sel = in_alias(MMIO_OFS) && alias_on;
    wire legal_sz = size_ok(MMIO_SIZE, MMIO_OFS);
    wire from_cpu = (MMIO_SRC == `SRC_CPU);
    wire from_link = (MMIO_SRC == `SRC_LINK);
    wire forward = alias_sel && legal_sz && from_cpu;

    always @(posedge CLK) begin
        if (!NRST) begin
            mstate <= M_IDLE;
            MMIO_ACK <= 1'b0;
            MMIO_RDATA <= 64'h0;
            MMIO_HIT <= 1'b0;
            MC_REQ <= 1'b0;
            MC_WR <= 1'b0;
            MC_OFS <= 24'h0;
            MC_SIZE <= `SZ_BYTE;
            MC_WDATA <= 64'h0;
            MC_BE <= 8'h0;
            MC_TRUSTED <= 1'b0;
        end else begin
            MMIO_ACK <= 1'b0;
            case (mstate)
                M_IDLE: begin
                    if (MMIO_REQ) begin
                        MMIO_HIT <= alias_sel && !from_link;
                        if (forward) begin
                            MC_REQ <= 1'b1;
                            MC_WR <= MMIO_WR;
                            MC_OFS <= MMIO_OFS - `ALIAS_LO;
                            MC_SIZE <= MMIO_SIZE;
                            MC_WDATA <= MMIO_WDATA;
                            MC_BE <= MMIO_BE;
                            MC_TRUSTED <= TRUSTED_LAUNCH_MODE;
                            mstate <= M_WAIT;
                        end else begin
                            // Load discarded, store and bad size read zero
                            MMIO_ACK <= 1'b1;
                            MMIO_RDATA <= 64'h0;
                        end
                    end
                end
                M_WAIT: begin
                    if (MC_ACK) begin
                        MC_REQ <= 1'b0;
                        MMIO_ACK <= 1'b1;
                        MMIO_RDATA <= MC_WR ? 64'h0 : MC_RDATA;
                        mstate <= M_IDLE;
                    end
                end
                default: mstate <= M_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Graphics memory address path
    // ---------------------------------------------------------------
    localparam G_IDLE = 3'h0;
    localparam G_LOOK = 3'h1;
    localparam G_FETCH = 3'h2;
    localparam G_MEM = 3'h3;
    reg [2:0] gstate;
    reg [31:0] zaddr;
    reg greq_wr;
    reg greq_cpu;

    wire [31:0] zero_based = GM_EXTERNAL ? GM_ADDR - GM_RANGE_BASE : GM_ADDR;

    // ---------------------------------------------------------------
    // Fence lookup and tiling
    // ---------------------------------------------------------------
    reg fenced;
    reg fwalk;
    reg [3:0] fpitch;
    integer f;
    always @* begin
        fenced = 1'b0;
        fwalk = 1'b0;
        fpitch = 4'h0;
        for (f = 0; f < `FENCE_N; f = f + 1) begin
            if (FENCE_VALID[f] && zaddr >= FENCE_LO[f*32 +: 32] &&
                zaddr <= FENCE_HI[f*32 +: 32]) begin
                fenced = 1'b1;
                fwalk = FENCE_WALK_Y[f];
                fpitch = FENCE_PITCH_LOG2[f*4 +: 4];
            end
        end
    end

    reg surf_tiled;
    reg surf_walk;
    reg [3:0] surf_pitch;
    wire [31:0] laddr;
    gfx_tiler tiler (
        .zaddr(zaddr),
        .tiled(fenced || surf_tiled),
        .walk_y(fenced ? fwalk : surf_walk),
        .pitch_tiles_log2(fenced ? fpitch : surf_pitch),
        .laddr(laddr)
    );

    // ---------------------------------------------------------------
    // Translation cache
    // ---------------------------------------------------------------
    wire tlb_hit;
    wire [27:0] tlb_frame;
    wire tlb_fill = (gstate == G_FETCH) && TT_ACK && TT_VALID;
    gfx_tlb tlb (
        .clk(CLK),
        .nrst(NRST),
        .flush(TLB_FLUSH),
        .lookup_page(laddr[31:12]),
        .hit(tlb_hit),
        .hit_frame(tlb_frame),
        .fill(tlb_fill),
        .fill_page(laddr[31:12]),
        .fill_frame(TT_FRAME)
    );

    // ---------------------------------------------------------------
    // Address path sequencer
    // ---------------------------------------------------------------
    always @(posedge CLK) begin
        if (!NRST) begin
            gstate <= G_IDLE;
            zaddr <= 32'h0;
            greq_wr <= 1'b0;
            greq_cpu <= 1'b0;
            surf_tiled <= 1'b0;
            surf_walk <= 1'b0;
            surf_pitch <= 4'h0;
            TT_REQ <= 1'b0;
            TT_PAGE <= 20'h0;
            PM_REQ <= 1'b0;
            PM_WR <= 1'b0;
            PM_ADDR <= 40'h0;
            PM_SNOOP <= 1'b0;
            GM_ACK <= 1'b0;
            GM_ERR <= 1'b0;
        end else begin
            GM_ACK <= 1'b0;
            GM_ERR <= 1'b0;
            case (gstate)
                G_IDLE: begin
                    if (GM_REQ) begin
                        if (client_ok(GM_SRC, GM_WR)) begin
                            zaddr <= zero_based;
                            greq_wr <= GM_WR;
                            greq_cpu <= (GM_SRC == `SRC_CPU);
                            surf_tiled <= GM_SURF_TILED;
                            surf_walk <= GM_SURF_WALK_Y;
                            surf_pitch <= GM_SURF_PITCH_LOG2;
                            PM_SNOOP <= (GM_SRC == `SRC_SNOOP);
                            gstate <= G_LOOK;
                        end else begin
                            GM_ACK <= 1'b1;
                            GM_ERR <= 1'b1;
                        end
                    end
                end
                G_LOOK: begin
                    if (tlb_hit) begin
                        PM_REQ <= 1'b1;
                        PM_WR <= greq_wr;
                        PM_ADDR <= {tlb_frame, laddr[11:0]};
                        gstate <= G_MEM;
                    end else begin
                        TT_REQ <= 1'b1;
                        TT_PAGE <= laddr[31:12];
                        gstate <= G_FETCH;
                    end
                end
                G_FETCH: begin
                    if (TT_ACK) begin
                        TT_REQ <= 1'b0;
                        if (TT_VALID) begin
                            gstate <= G_LOOK;
                        end else begin
                            // CPU reads through invalid entries complete silently
                            GM_ACK <= 1'b1;
                            GM_ERR <= !(greq_cpu && !greq_wr);
                            gstate <= G_IDLE;
                        end
                    end
                end
                G_MEM: begin
                    if (PM_ACK) begin
                        PM_REQ <= 1'b0;
                        GM_ACK <= 1'b1;
                        gstate <= G_IDLE;
                    end
                end
                default: gstate <= G_IDLE;
            endcase
        end
    end
endmodule

// ==== test/gfx_mi_front_monitor.sv ====
`include "gfx_mi_defines.vh"

module gfx_mi_front_monitor (
    // Clock and reset
    input logic CLK,
    input logic NRST,
    // MMIO side
    input logic [3:0] MMIO_SRC,
    input logic [23:0] MMIO_OFS,
    input logic [7:0] MMIO_BE,
    input logic MMIO_ACK,
    input logic [63:0] MMIO_RDATA,
    input logic TRUSTED_LAUNCH_MODE,
    // Controller side
    input logic MC_REQ,
    input logic MC_WR,
    input logic [23:0] MC_OFS,
    input logic [1:0] MC_SIZE,
    input logic MC_TRUSTED,
    input logic [7:0] MC_BE,
    input logic MC_ACK,
    input logic [63:0] MC_RDATA,
    // Memory client side
    input logic [3:0] GM_SRC,
    input logic GM_WR,
    input logic PM_REQ,
    input logic PM_WR,
    input logic PM_SNOOP
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_cpu_only: assert property ($rose(MC_REQ) |-> $past(MMIO_SRC) == `SRC_CPU)
        else $error("alias forwarded for other source");
    chk_in_window: assert property ($rose(MC_REQ) |-> $past(MMIO_OFS) >= `ALIAS_LO
        && $past(MMIO_OFS) <= `ALIAS_HI) else $error("forward outside window");
    chk_alias_ofs: assert property ($rose(MC_REQ) |-> MC_OFS == $past(MMIO_OFS) - 24'h140000)
        else $error("controller offset wrong");
    chk_size_align: assert property (MC_REQ |-> MC_SIZE != `SZ_BYTE
        && (MC_OFS & ((24'h1 << MC_SIZE) - 24'h1)) == 24'h0) else $error("bad size");
    chk_trust_pass: assert property ($rose(MC_REQ) |-> MC_TRUSTED == $past(TRUSTED_LAUNCH_MODE))
        else $error("trusted mode not passed");
    chk_refuse_zero: assert property (MMIO_ACK && !$past(MC_ACK) |-> MMIO_RDATA == 64'h0)
        else $error("refused access returned data");
    chk_read_pass: assert property (MMIO_ACK && $past(MC_ACK) && !$past(MC_WR)
        |-> MMIO_RDATA == $past(MC_RDATA)) else $error("read data not passed");
    chk_ack_bound: assert property ($rose(MC_REQ) |-> ##[1:20] MMIO_ACK)
        else $error("no answer to alias access");
    chk_snoop_kind: assert property (PM_REQ |-> PM_SNOOP == (GM_SRC == `SRC_SNOOP))
        else $error("snoop attribute wrong");
    chk_write_dir: assert property (PM_REQ |-> PM_WR == GM_WR)
        else $error("memory direction wrong");
    chk_be_pass: assert property ($rose(MC_REQ) |-> MC_BE == $past(MMIO_BE))
        else $error("byte enables not passed");
    chk_ro_nowrite: assert property (PM_REQ && PM_WR |->
        !(GM_SRC inside {`SRC_CMD, `SRC_VTX, `SRC_ISC, `SRC_SMP, `SRC_DISP}))
        else $error("write from read only client");
    chk_wo_noread: assert property (PM_REQ && !PM_WR |->
        !(GM_SRC inside {`SRC_PEG, `SRC_PEER})) else $error("read from write only client");
endmodule

bind gfx_mi_front gfx_mi_front_monitor u_gfx_mi_front_monitor (.*);

// ==== test/gfx_mem_side.sv ====
module gfx_mem_side #(
    parameter int DLY = 2
) (
    // Clock and reset
    input logic CLK,
    input logic NRST,
    // Controller register space
    input logic MC_REQ,
    input logic MC_WR,
    input logic [63:0] MC_WDATA,
    output logic MC_ACK,
    output logic [63:0] MC_RDATA,
    // Translation table
    input logic TT_REQ,
    input logic [19:0] TT_PAGE,
    output logic TT_ACK,
    output logic [27:0] TT_FRAME,
    output logic TT_VALID,
    // Physical memory
    input logic PM_REQ,
    output logic PM_ACK
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] regv;
    logic [3:0] cm, ct, cp;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            {MC_ACK, TT_ACK, PM_ACK, cm, ct, cp} <= '0;
            {regv, MC_RDATA, TT_FRAME, TT_VALID} <= '0;
        end else begin
            cm <= (MC_REQ && !MC_ACK) ? cm + 4'h1 : 4'h0;
            ct <= (TT_REQ && !TT_ACK) ? ct + 4'h1 : 4'h0;
            cp <= (PM_REQ && !PM_ACK) ? cp + 4'h1 : 4'h0;
            MC_ACK <= MC_REQ && !MC_ACK && cm == 4'(DLY);
            TT_ACK <= TT_REQ && !TT_ACK && ct == 4'(DLY);
            PM_ACK <= PM_REQ && !PM_ACK && cp == 4'(DLY);
            // Not answering: read data, frame and valid keep changing
            MC_RDATA <= ~MC_RDATA;
            TT_FRAME <= ~TT_FRAME;
            TT_VALID <= ~TT_VALID;
            if (MC_REQ && !MC_ACK && cm == 4'(DLY)) begin
                MC_RDATA <= regv;
                if (MC_WR) begin
                    regv <= MC_WDATA;
                end
            end
            if (TT_REQ && !TT_ACK && ct == 4'(DLY)) begin
                TT_FRAME <= {8'h00, TT_PAGE} + 28'h0001000;
                TT_VALID <= 1'b1;
            end
        end
    end
endmodule

// ==== test/gfx_mi_front_tb.sv ====
`include "gfx_mi_defines.vh"

module gfx_mi_front_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] D1 = 64'h0123456789abcdef;
    logic CLK, NRST, MMIO_REQ, MMIO_WR, MMIO_FUNC, FUNC0_MEM_EN, FUNC1_MEM_EN, ALIAS_POWER_OK;
    logic [3:0] MMIO_SRC, GM_SRC, GM_SURF_PITCH_LOG2, FENCE_VALID, FENCE_WALK_Y;
    logic [23:0] MMIO_OFS, MC_OFS;
    logic [1:0] MMIO_SIZE, MC_SIZE;
    logic [63:0] MMIO_WDATA, MMIO_RDATA, MC_WDATA, MC_RDATA, rd, pa;
    logic [7:0] MMIO_BE, MC_BE;
    logic MMIO_ACK, MMIO_HIT, MC_REQ, MC_WR, MC_TRUSTED, TRUSTED_LAUNCH_MODE, MC_ACK;
    logic GM_REQ, GM_WR, GM_EXTERNAL, GM_SURF_TILED, GM_SURF_WALK_Y, TT_REQ, TT_ACK, TT_VALID;
    logic TLB_FLUSH, PM_REQ, PM_WR, PM_SNOOP, PM_ACK, GM_ACK, GM_ERR, hit, err;
    logic [31:0] GM_ADDR, GM_RANGE_BASE;
    logic [127:0] FENCE_LO, FENCE_HI;
    logic [15:0] FENCE_PITCH_LOG2;
    logic [19:0] TT_PAGE;
    logic [27:0] TT_FRAME;
    logic [39:0] PM_ADDR;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    gfx_mi_front u_gfx_mi_front (.*);
    gfx_mem_side #(.DLY(2)) u_gfx_mem_side (.*);

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test;
        end
    end

    task automatic finish_test;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: value %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_flag(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: flag %b expected %b", $time, g, e);
        end
    endtask

    function automatic logic [63:0] exp_pa(input logic [31:0] z);
        return {24'h0, {8'h00, z[31:12]} + 28'h0001000, z[11:0]};
    endfunction

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic mmio(input logic w, input logic f, input logic [3:0] s,
        input logic [23:0] o, input logic [1:0] z, input logic [63:0] d);
        rd = 'x;
        hit = 1'bx;
        @(posedge CLK);
        {MMIO_REQ, MMIO_WR, MMIO_FUNC, MMIO_SRC} <= {1'b1, w, f, s};
        {MMIO_OFS, MMIO_SIZE, MMIO_WDATA} <= {o, z, d};
        @(posedge CLK);
        MMIO_REQ <= 1'b0;
        for (int k = 0; k < 40; k++) begin
            #1;
            if (MMIO_ACK === 1'b1) begin
                rd = MMIO_RDATA;
                hit = MMIO_HIT;
                break;
            end
            @(posedge CLK);
        end
        chk_flag(hit !== 1'bx, 1'b1);
        @(posedge CLK);
    endtask

    task automatic gm(input logic w, input logic [3:0] s, input logic [31:0] a, input logic x);
        pa = 'x;
        err = 1'bx;
        @(posedge CLK);
        {GM_REQ, GM_WR, GM_SRC, GM_ADDR, GM_EXTERNAL} <= {1'b1, w, s, a, x};
        @(posedge CLK);
        GM_REQ <= 1'b0;
        for (int k = 0; k < 60; k++) begin
            #1;
            if (PM_REQ === 1'b1) pa = {24'h0, PM_ADDR};
            if (GM_ACK === 1'b1) begin
                err = GM_ERR;
                break;
            end
            @(posedge CLK);
        end
        @(posedge CLK);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_alias_rw;
        TRUSTED_LAUNCH_MODE <= 1'b1;
        mmio(1'b1, 1'b0, `SRC_CPU, 24'h140008, `SZ_QWORD, D1);
        mmio(1'b0, 1'b0, `SRC_CPU, 24'h140008, `SZ_QWORD, 64'h0);
        chk_data(rd, D1);
        chk_flag(hit, 1'b1);
        TRUSTED_LAUNCH_MODE <= 1'b0;
        mmio(1'b0, 1'b1, `SRC_CPU, 24'h17fffe, `SZ_WORD, 64'h0);
        chk_flag(hit, 1'b1);
        mmio(1'b0, 1'b0, `SRC_CPU, 24'h180000, `SZ_DWORD, 64'h0);
        chk_data(rd, 64'h0);
    endtask

    task automatic t_refuse;
        for (int s = 1; s <= 10; s++) begin
            mmio(1'b1, 1'b0, s[3:0], 24'h140008, `SZ_QWORD, ~D1);
            mmio(1'b0, 1'b0, s[3:0], 24'h140008, `SZ_QWORD, 64'h0);
            chk_data(rd, 64'h0);
            if (s == 3) chk_flag(hit, 1'b0);
        end
        mmio(1'b0, 1'b0, `SRC_CPU, 24'h140008, `SZ_QWORD, 64'h0);
        chk_data(rd, D1);
    endtask

    task automatic t_sizes;
        mmio(1'b1, 1'b0, `SRC_CPU, 24'h140008, `SZ_BYTE, ~D1);
        mmio(1'b1, 1'b0, `SRC_CPU, 24'h140006, `SZ_DWORD, ~D1);
        mmio(1'b0, 1'b0, `SRC_CPU, 24'h140008, `SZ_BYTE, 64'h0);
        chk_data(rd, 64'h0);
        mmio(1'b0, 1'b0, `SRC_CPU, 24'h140008, `SZ_QWORD, 64'h0);
        chk_data(rd, D1);
    endtask

    task automatic t_disable;
        FUNC0_MEM_EN <= 1'b0;
        repeat (4) @(posedge CLK);
        mmio(1'b0, 1'b0, `SRC_CPU, 24'h140008, `SZ_QWORD, 64'h0);
        chk_data(rd, 64'h0);
        mmio(1'b0, 1'b1, `SRC_CPU, 24'h140008, `SZ_QWORD, 64'h0);
        chk_data(rd, D1);
        FUNC0_MEM_EN <= 1'b1;
        ALIAS_POWER_OK <= 1'b0;
        repeat (4) @(posedge CLK);
        mmio(1'b0, 1'b1, `SRC_CPU, 24'h140008, `SZ_QWORD, 64'h0);
        chk_data(rd, 64'h0);
        ALIAS_POWER_OK <= 1'b1;
        repeat (4) @(posedge CLK);
    endtask

    task automatic t_clients;
        logic ro, wo, x;
        TLB_FLUSH <= 1'b1;
        @(posedge CLK);
        TLB_FLUSH <= 1'b0;
        for (int i = 0; i < 22; i++) begin
            if (i / 2 == 3) continue;
            ro = i / 2 >= 5 && i / 2 != 8;
            wo = i / 2 == 1 || i / 2 == 2;
            x = i / 2 < 3;
            gm(i[0], 4'(i / 2), x ? GM_RANGE_BASE + 32'h3abc : 32'h3abc, x);
            chk_flag(err, i[0] ? ro : wo);
            if (!(i[0] ? ro : wo)) chk_data(pa, exp_pa(32'h3abc));
        end
    endtask

    task automatic t_tiling;
        FENCE_HI <= {96'h0, 32'h0000ffff};
        FENCE_PITCH_LOG2 <= 16'h0001;
        FENCE_VALID <= 4'h1;
        gm(1'b0, `SRC_RCC, 32'h200, 1'b0);
        chk_data(pa, exp_pa(32'h1000));
        FENCE_VALID <= 4'h0;
        GM_SURF_TILED <= 1'b1;
        GM_SURF_PITCH_LOG2 <= 4'h1;
        gm(1'b0, `SRC_RCC, 32'h200, 1'b0);
        chk_data(pa, exp_pa(32'h1000));
        GM_SURF_TILED <= 1'b0;
        gm(1'b0, `SRC_RCC, 32'h200, 1'b0);
        chk_data(pa, exp_pa(32'h200));
        GM_SURF_TILED <= 1'b1;
        GM_SURF_WALK_Y <= 1'b1;
        gm(1'b0, `SRC_RCC, 32'h110, 1'b0);
        chk_data(pa, exp_pa(32'h210));
        GM_SURF_TILED <= 1'b0;
        GM_SURF_WALK_Y <= 1'b0;
    endtask

    initial begin
        {NRST, MMIO_REQ, MMIO_WR, MMIO_FUNC, MMIO_SRC, MMIO_OFS, MMIO_SIZE, MMIO_WDATA} = '0;
        {TRUSTED_LAUNCH_MODE, GM_REQ, GM_WR, GM_SRC, GM_ADDR, GM_EXTERNAL} = '0;
        {GM_SURF_TILED, GM_SURF_WALK_Y, GM_SURF_PITCH_LOG2, TLB_FLUSH} = '0;
        {FENCE_LO, FENCE_HI, FENCE_VALID, FENCE_WALK_Y, FENCE_PITCH_LOG2} = '0;
        {FUNC0_MEM_EN, FUNC1_MEM_EN, ALIAS_POWER_OK} = 3'h7;
        MMIO_BE = 8'hff;
        GM_RANGE_BASE = 32'h80000000;
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge CLK);
        t_alias_rw;
        t_refuse;
        t_sizes;
        t_disable;
        t_clients;
        t_tiling;
        finish_test;
    end
endmodule
